//--- design/dsd_defs.vh
// Address map, field positions and constants of the data-space decoder.
`ifndef DSD_DEFS_VH
`define DSD_DEFS_VH
// =====================================================================
// Data-space map
`define DSD_WIN_LO 8'h40
`define DSD_WIN_HI 8'h7f
`define DSD_PTR0_ADDR 8'h80
`define DSD_PTR1_ADDR 8'h81
`define DSD_SDIR0_ADDR 8'h82
`define DSD_SDIR1_ADDR 8'h83
`define DSD_RAM_LO 8'h84
`define DSD_RAM_HI 8'hbf
`define DSD_PORT0_DATA 8'hc0
`define DSD_PORT1_DATA 8'hc1
`define DSD_PORT0_DIR 8'hc4
`define DSD_PORT1_DIR 8'hc5
`define DSD_INT_OPT 8'hc8
`define DSD_WIN_POS 8'hc9
`define DSD_PORT0_OPT 8'hcc
`define DSD_PORT1_OPT 8'hcd
`define DSD_CONV_RES 8'hd0
`define DSD_CONV_CTL 8'hd1
`define DSD_TMR_PRE 8'hd2
`define DSD_TMR_CNT 8'hd3
`define DSD_TMR_STAT 8'hd4
`define DSD_ACC_ADDR 8'hff
// =====================================================================
// Fields and widths
`define DSD_WIN_OFS_W 6
`define DSD_WIN_POS_W 6
`define DSD_PC_W 12
`define DSD_STACK_DEPTH 6
`define DSD_RAM_WORDS 60
`define DSD_IDLE_READ 8'hff
// =====================================================================
// Peripheral select one-hot positions
`define DSD_PSEL_W 13
`define DSD_PSEL_P0D 0
`define DSD_PSEL_P1D 1
`define DSD_PSEL_P0R 2
`define DSD_PSEL_P1R 3
`define DSD_PSEL_IOPT 4
`define DSD_PSEL_P0O 5
`define DSD_PSEL_P1O 6
`define DSD_PSEL_CRES 7
`define DSD_PSEL_CCTL 8
`define DSD_PSEL_TPRE 9
`define DSD_PSEL_TCNT 10
`define DSD_PSEL_TSTA 11
`define DSD_PSEL_WDOG 12
`define DSD_WDOG_ADDR 8'hd8
`endif

//--- design/dsd_return_stack.v
// Hardware return stack of program addresses.
`timescale 1ns/1ps
module dsd_return_stack #(
   parameter WIDTH = 12,
   parameter DEPTH = 6
) (
   input wire clk,
   input wire sys_rst,
   input wire push,
   input wire pop,
   input wire [WIDTH-1:0] push_addr,
   output reg [WIDTH-1:0] top_addr,
   output reg overflow,
   output reg underflow
);
   // =====================================================================
   // Storage
   reg [WIDTH-1:0] slot_reg [0:DEPTH-1];
   reg [3:0] level_reg;
   integer i;

   always @(posedge clk) begin
      if (sys_rst) begin
         level_reg <= 4'h0;
         overflow <= 1'b0;
         underflow <= 1'b0;
         top_addr <= {WIDTH{1'b0}};
      end else begin
         overflow <= push && !pop && (level_reg == DEPTH[3:0]);
         underflow <= pop && !push && (level_reg == 4'h0);
         // A push beyond the last level shifts out the oldest entry, as a real shift stack does.
         if (push && !pop) begin
            slot_reg[0] <= push_addr;
            for (i = 1; i < DEPTH; i = i + 1) begin
               slot_reg[i] <= slot_reg[i-1];
            end
            if (level_reg != DEPTH[3:0]) begin
               level_reg <= level_reg + 4'h1;
            end
            top_addr <= push_addr;
         end else if (pop && !push) begin
            for (i = 0; i < DEPTH-1; i = i + 1) begin
               slot_reg[i] <= slot_reg[i+1];
            end
            if (level_reg != 4'h0) begin
               level_reg <= level_reg - 4'h1;
            end
            top_addr <= slot_reg[1];
         end
      end
   end
endmodule // dsd_return_stack

//--- design/dsd_decoder.v
// Data-space decoder with the program-memory read window.
`timescale 1ns/1ps
`include "dsd_defs.vh"
module dsd_decoder #(
   parameter HAS_CONVERTER = 1,
   parameter PC_W = `DSD_PC_W,
   parameter STACK_DEPTH = `DSD_STACK_DEPTH
) (
   input wire clk,
   input wire sys_rst,
   input wire [7:0] cpu_addr,
   input wire cpu_rd,
   input wire cpu_wr,
   input wire [7:0] cpu_wdata,
   output reg [7:0] cpu_rdata,
   output reg cpu_rvalid,
   input wire [7:0] acc_in,
   output reg [7:0] acc_wdata,
   output reg acc_we,
   output reg [7:0] ptr0_out,
   output reg [7:0] ptr1_out,
   output reg [7:0] sdir0_out,
   output reg [7:0] sdir1_out,
   input wire fetch_req,
   input wire [PC_W-1:0] fetch_pc,
   output reg fetch_valid,
   output reg [7:0] fetch_data,
   output reg [PC_W-1:0] pmem_addr,
   output reg pmem_en,
   input wire [7:0] pmem_rdata,
   input wire call_push,
   input wire ret_pop,
   output reg [PC_W-1:0] stack_top,
   output reg stack_overflow,
   output reg stack_underflow,
   output reg [`DSD_PSEL_W-1:0] periph_sel,
   output reg periph_rd,
   output reg periph_wr,
   output reg [7:0] periph_wdata,
   input wire [7:0] periph_rdata,
   input wire readout_protect,
   input wire ext_read_req,
   input wire [PC_W-1:0] ext_read_addr,
   output reg [7:0] ext_read_data,
   output reg ext_read_valid,
   input wire test_pin_high,
   output reg prog_mode
);
   // =====================================================================
   // Decode
   localparam [4:0] T_WIN = 5'h01;
   localparam [4:0] T_RAM = 5'h02;
   localparam [4:0] T_CORE = 5'h04;
   localparam [4:0] T_PER = 5'h08;
   localparam [4:0] T_NONE = 5'h10;

   function [`DSD_PSEL_W-1:0] psel_of;
      input [7:0] a;
      begin
         psel_of = {`DSD_PSEL_W{1'b0}};
         case (a)
            `DSD_PORT0_DATA: psel_of[`DSD_PSEL_P0D] = 1'b1;
            `DSD_PORT1_DATA: psel_of[`DSD_PSEL_P1D] = 1'b1;
            `DSD_PORT0_DIR: psel_of[`DSD_PSEL_P0R] = 1'b1;
            `DSD_PORT1_DIR: psel_of[`DSD_PSEL_P1R] = 1'b1;
            `DSD_INT_OPT: psel_of[`DSD_PSEL_IOPT] = 1'b1;
            `DSD_PORT0_OPT: psel_of[`DSD_PSEL_P0O] = 1'b1;
            `DSD_PORT1_OPT: psel_of[`DSD_PSEL_P1O] = 1'b1;
            `DSD_CONV_RES: psel_of[`DSD_PSEL_CRES] = (HAS_CONVERTER != 0);
            `DSD_CONV_CTL: psel_of[`DSD_PSEL_CCTL] = (HAS_CONVERTER != 0);
            `DSD_TMR_PRE: psel_of[`DSD_PSEL_TPRE] = 1'b1;
            `DSD_TMR_CNT: psel_of[`DSD_PSEL_TCNT] = 1'b1;
            `DSD_TMR_STAT: psel_of[`DSD_PSEL_TSTA] = 1'b1;
            `DSD_WDOG_ADDR: psel_of[`DSD_PSEL_WDOG] = 1'b1;
            default: psel_of = {`DSD_PSEL_W{1'b0}};
         endcase
      end
   endfunction

   function [4:0] target_of;
      input [7:0] a;
      begin
         if (a >= `DSD_WIN_LO && a <= `DSD_WIN_HI) begin
            target_of = T_WIN;
         end else if (a >= `DSD_RAM_LO && a <= `DSD_RAM_HI) begin
            target_of = T_RAM;
         end else if (a == `DSD_ACC_ADDR || a == `DSD_WIN_POS || (a >= `DSD_PTR0_ADDR && a <= `DSD_SDIR1_ADDR)) begin
            target_of = T_CORE;
         end else if (psel_of(a) != {`DSD_PSEL_W{1'b0}}) begin
            target_of = T_PER;
         end else begin
            target_of = T_NONE;
         end
      end
   endfunction

   wire [4:0] tgt = target_of(cpu_addr);
   wire [`DSD_PSEL_W-1:0] psel = psel_of(cpu_addr);

   // =====================================================================
   // Storage
   reg [7:0] ram_mem [0:`DSD_RAM_WORDS-1];
   wire [7:0] ram_idx = cpu_addr - `DSD_RAM_LO;
   reg [`DSD_WIN_POS_W-1:0] win_pos_reg;
   reg [7:0] ram_rd_reg;
   reg [4:0] tgt_reg;
   reg rd_pend_reg;
   reg [7:0] core_rd_reg;
   reg [PC_W-1:0] fetch_pend_pc_reg;
   reg fetch_pend_reg;
   reg pm_win_reg;
   reg pm_fetch_reg;
   reg pm_ext_reg;
   reg rst_seen_reg;

   // The position register is left without reset so software sees the documented undefined start.
   always @(posedge clk) begin
      if (cpu_wr && cpu_addr == `DSD_WIN_POS) begin
         win_pos_reg <= cpu_wdata[`DSD_WIN_POS_W-1:0];
      end
      if (cpu_wr && tgt == T_RAM) begin
         ram_mem[ram_idx[5:0]] <= cpu_wdata;
      end
      ram_rd_reg <= ram_mem[ram_idx[5:0]];
   end

   // =====================================================================
   // Program memory arbitration
   // The window read wins the port; a colliding fetch is held until a cycle with no window read so neither is corrupted.
   wire win_rd = cpu_rd && tgt == T_WIN;
   wire fetch_any = fetch_req || fetch_pend_reg;
   wire [PC_W-1:0] fetch_addr = fetch_pend_reg ? fetch_pend_pc_reg : fetch_pc;
   wire ext_ok = ext_read_req && !readout_protect && !win_rd && !fetch_any;

   always @(posedge clk) begin
      if (sys_rst) begin
         pmem_en <= 1'b0;
         pmem_addr <= {PC_W{1'b0}};
         pm_win_reg <= 1'b0;
         pm_fetch_reg <= 1'b0;
         pm_ext_reg <= 1'b0;
         fetch_pend_reg <= 1'b0;
         fetch_pend_pc_reg <= {PC_W{1'b0}};
      end else begin
         pm_win_reg <= win_rd;
         pm_fetch_reg <= fetch_any && !win_rd;
         pm_ext_reg <= ext_ok;
         pmem_en <= win_rd || fetch_any || ext_ok;
         if (win_rd) begin
            pmem_addr <= {win_pos_reg, cpu_addr[`DSD_WIN_OFS_W-1:0]};
            fetch_pend_reg <= fetch_any;
            if (fetch_req && !fetch_pend_reg) begin
               fetch_pend_pc_reg <= fetch_pc;
            end
         end else if (fetch_any) begin
            pmem_addr <= fetch_addr;
            fetch_pend_reg <= 1'b0;
         end else if (ext_ok) begin
            pmem_addr <= ext_read_addr;
         end
      end
   end

   always @(posedge clk) begin
      if (sys_rst) begin
         fetch_valid <= 1'b0;
         fetch_data <= 8'h00;
         ext_read_valid <= 1'b0;
         ext_read_data <= 8'h00;
      end else begin
         fetch_valid <= pm_fetch_reg;
         fetch_data <= pm_fetch_reg ? pmem_rdata : fetch_data;
         ext_read_valid <= pm_ext_reg || (ext_read_req && readout_protect);
         // A protected part answers every outside read with a blank byte.
         ext_read_data <= pm_ext_reg ? pmem_rdata : `DSD_IDLE_READ;
      end
   end

   // =====================================================================
   // Core registers and CPU access
   always @(posedge clk) begin
      if (sys_rst) begin
         ptr0_out <= 8'h00;
         ptr1_out <= 8'h00;
         sdir0_out <= 8'h00;
         sdir1_out <= 8'h00;
         acc_we <= 1'b0;
         acc_wdata <= 8'h00;
         tgt_reg <= T_NONE;
         rd_pend_reg <= 1'b0;
         core_rd_reg <= `DSD_IDLE_READ;
         cpu_rvalid <= 1'b0;
         cpu_rdata <= 8'h00;
         periph_sel <= {`DSD_PSEL_W{1'b0}};
         periph_rd <= 1'b0;
         periph_wr <= 1'b0;
         periph_wdata <= 8'h00;
      end else begin
         acc_we <= cpu_wr && cpu_addr == `DSD_ACC_ADDR;
         acc_wdata <= cpu_wdata;
         if (cpu_wr) begin
            case (cpu_addr)
               `DSD_PTR0_ADDR: ptr0_out <= cpu_wdata;
               `DSD_PTR1_ADDR: ptr1_out <= cpu_wdata;
               `DSD_SDIR0_ADDR: sdir0_out <= cpu_wdata;
               `DSD_SDIR1_ADDR: sdir1_out <= cpu_wdata;
               default: ptr0_out <= ptr0_out;
            endcase
         end
         case (cpu_addr)
            `DSD_PTR0_ADDR: core_rd_reg <= ptr0_out;
            `DSD_PTR1_ADDR: core_rd_reg <= ptr1_out;
            `DSD_SDIR0_ADDR: core_rd_reg <= sdir0_out;
            `DSD_SDIR1_ADDR: core_rd_reg <= sdir1_out;
            `DSD_ACC_ADDR: core_rd_reg <= acc_in;
            default: core_rd_reg <= `DSD_IDLE_READ;
         endcase
         tgt_reg <= cpu_rd ? tgt : T_NONE;
         rd_pend_reg <= cpu_rd;
         periph_sel <= (cpu_rd || cpu_wr) ? psel : {`DSD_PSEL_W{1'b0}};
         periph_rd <= cpu_rd && tgt == T_PER && !psel[`DSD_PSEL_IOPT];
         periph_wr <= cpu_wr && tgt == T_PER;
         periph_wdata <= cpu_wdata;
         // Every read answers two cycles after the request whatever the target.
         cpu_rvalid <= rd_pend_reg;
         case (tgt_reg)
            T_WIN: cpu_rdata <= pmem_rdata;
            T_RAM: cpu_rdata <= ram_rd_reg;
            T_CORE: cpu_rdata <= core_rd_reg;
            T_PER: cpu_rdata <= periph_sel[`DSD_PSEL_IOPT] ? `DSD_IDLE_READ : periph_rdata;
            default: cpu_rdata <= `DSD_IDLE_READ;
         endcase
      end
   end

   // =====================================================================
   // Programming mode strap
   always @(posedge clk) begin
      if (sys_rst) begin
         rst_seen_reg <= 1'b1;
         prog_mode <= 1'b0;
      end else begin
         rst_seen_reg <= 1'b0;
         if (rst_seen_reg) begin
            prog_mode <= test_pin_high;
         end
      end
   end

   // =====================================================================
   // Return stack
   wire [PC_W-1:0] stk_top;
   wire stk_ovf;
   wire stk_unf;
   dsd_return_stack #(.WIDTH(PC_W), .DEPTH(STACK_DEPTH)) u_stack (
      .clk(clk),
      .sys_rst(sys_rst),
      .push(call_push),
      .pop(ret_pop),
      .push_addr(fetch_pc),
      .top_addr(stk_top),
      .overflow(stk_ovf),
      .underflow(stk_unf)
   );

   always @(posedge clk) begin
      stack_top <= stk_top;
      stack_overflow <= stk_ovf;
      stack_underflow <= stk_unf;
   end
endmodule // dsd_decoder

//--- tb/dsd_pmem_model.sv
// Combinational program memory model on the far side of the decoder.
`timescale 1ns/1ps
// ==========
// Program memory
module dsd_pmem_model (
   input wire pmem_en,
   input wire [11:0] pmem_addr,
   output reg [7:0] pmem_rdata
);
   // The decoder takes the byte at the edge after it drives the address, so the array answers at once.
   // Without the enable the bus shows the inverse, so stale data never passes for a fetch.
   always @* begin
      pmem_rdata = pmem_addr[7:0] ^ {pmem_addr[11:8], pmem_addr[11:8]};
      if (!pmem_en) begin
         pmem_rdata = ~pmem_rdata;
      end
   end
endmodule // dsd_pmem_model

//--- tb/dsd_decoder_chk.sv
// Port assertions for the data-space decoder.
`timescale 1ns/1ps
`include "dsd_defs.vh"
// ==========
// Checker
module dsd_decoder_chk #(
   parameter PC_W = 12
) (
   input wire clk,
   input wire sys_rst,
   input wire [7:0] cpu_addr,
   input wire cpu_rd,
   input wire cpu_wr,
   input wire [7:0] cpu_wdata,
   input wire [7:0] cpu_rdata,
   input wire cpu_rvalid,
   input wire [7:0] acc_wdata,
   input wire acc_we,
   input wire [7:0] ptr0_out,
   input wire fetch_req,
   input wire fetch_valid,
   input wire [PC_W-1:0] pmem_addr,
   input wire pmem_en,
   input wire [`DSD_PSEL_W-1:0] periph_sel,
   input wire periph_rd,
   input wire periph_wr
);
   // The position register has no reset, so neither has this shadow copy.
   reg [5:0] pos_reg;
   wire win_rd = cpu_rd && cpu_addr[7:6] == 2'b01;
   always @(posedge clk) begin
      if (cpu_wr && cpu_addr == 8'hc9) begin
         pos_reg <= cpu_wdata[5:0];
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   sequence s_win_req;
      win_rd;
   endsequence
   sequence s_win_fetch;
      pmem_en && !periph_rd && pmem_addr == {pos_reg, $past(cpu_addr[5:0])};
   endsequence
   a_win_addr: assert property (s_win_req |=> s_win_fetch)
      else $error("window read formed a wrong program address");
   a_rd_latency: assert property (cpu_rd |-> ##2 cpu_rvalid)
      else $error("read data not marked two cycles after request");
   a_wo_idle: assert property (cpu_rd && (cpu_addr == 8'hc8 || cpu_addr == 8'hc9) |=> !periph_rd ##1 cpu_rdata == 8'hff)
      else $error("write-only register read did not return idle value");
   a_rsv_read: assert property (cpu_rd && cpu_addr < 8'h40 |-> ##2 cpu_rdata == 8'hff)
      else $error("reserved read did not return idle value");
   a_rsv_write: assert property (cpu_wr && cpu_addr < 8'h40 |=> !periph_wr && !acc_we)
      else $error("reserved write had a side effect");
   a_acc_write: assert property (cpu_wr && cpu_addr == 8'hff |=> acc_we && acc_wdata == $past(cpu_wdata))
      else $error("accumulator write not passed on");
   a_ptr_write: assert property (cpu_wr && cpu_addr == 8'h80 |=> ptr0_out == $past(cpu_wdata))
      else $error("first pointer not written");
   a_port_route: assert property (cpu_wr && cpu_addr == 8'hc0 |=> periph_wr && periph_sel == 13'h0001)
      else $error("first port data write misrouted");
   a_fetch_lat: assert property (fetch_req && !win_rd |-> ##2 fetch_valid)
      else $error("instruction fetch not answered in two cycles");
endmodule // dsd_decoder_chk

bind dsd_decoder dsd_decoder_chk #(.PC_W(PC_W)) u_chk (.clk(clk), .sys_rst(sys_rst), .cpu_addr(cpu_addr),
   .cpu_rd(cpu_rd), .cpu_wr(cpu_wr), .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata), .cpu_rvalid(cpu_rvalid),
   .acc_wdata(acc_wdata), .acc_we(acc_we), .ptr0_out(ptr0_out), .fetch_req(fetch_req),
   .fetch_valid(fetch_valid), .pmem_addr(pmem_addr), .pmem_en(pmem_en), .periph_sel(periph_sel),
   .periph_rd(periph_rd), .periph_wr(periph_wr));

//--- tb/dsd_decoder_tb_top.sv
// Self-checking bench for the data-space decoder.
`timescale 1ns/1ps
`include "dsd_defs.vh"
// ==========
// Bench
module dsd_decoder_tb_top;
   localparam [103:0] PTAB = {8'hd8, 8'hd4, 8'hd3, 8'hd2, 8'hd1, 8'hd0, 8'hcd, 8'hcc, 8'hc8, 8'hc5, 8'hc4, 8'hc1,
      8'hc0};
   localparam [47:0] RSV = {8'hce, 8'hc3, 8'h00, 8'h3f, 8'hc8, 8'hd9};
   reg clk, sys_rst, cpu_rd, cpu_wr, fetch_req, test_pin_high;
   reg call_push, ret_pop, readout_protect, ext_read_req;
   reg [7:0] cpu_addr, cpu_wdata, acc_in, periph_rdata, got, fd, d, a, ed;
   reg [11:0] fetch_pc, pc, ext_read_addr;
   reg [11:0] pcs [0:6];
   wire [7:0] ext_read_data;
   wire [11:0] stack_top;
   wire stack_overflow, stack_underflow, ext_read_valid;
   reg [5:0] pos;
   wire [7:0] cpu_rdata, acc_wdata, ptr0_out, ptr1_out, sdir0_out, sdir1_out, fetch_data, pmem_rdata, periph_wdata;
   wire cpu_rvalid, acc_we, fetch_valid, pmem_en, periph_rd, periph_wr, prog_mode;
   wire [11:0] pmem_addr;
   wire [`DSD_PSEL_W-1:0] periph_sel;
   integer failures, comparisons, seed, cyc, i;
   dsd_decoder DUT (.clk(clk), .sys_rst(sys_rst), .cpu_addr(cpu_addr), .cpu_rd(cpu_rd), .cpu_wr(cpu_wr),
      .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata), .cpu_rvalid(cpu_rvalid), .acc_in(acc_in),
      .acc_wdata(acc_wdata), .acc_we(acc_we), .ptr0_out(ptr0_out), .ptr1_out(ptr1_out), .sdir0_out(sdir0_out),
      .sdir1_out(sdir1_out), .fetch_req(fetch_req), .fetch_pc(fetch_pc), .fetch_valid(fetch_valid),
      .fetch_data(fetch_data), .pmem_addr(pmem_addr), .pmem_en(pmem_en), .pmem_rdata(pmem_rdata),
      .call_push(call_push), .ret_pop(ret_pop), .stack_top(stack_top), .stack_overflow(stack_overflow),
      .stack_underflow(stack_underflow),
      .periph_sel(periph_sel), .periph_rd(periph_rd), .periph_wr(periph_wr), .periph_wdata(periph_wdata),
      .periph_rdata(periph_rdata), .readout_protect(readout_protect), .ext_read_req(ext_read_req),
      .ext_read_addr(ext_read_addr), .ext_read_data(ext_read_data), .ext_read_valid(ext_read_valid),
      .test_pin_high(test_pin_high), .prog_mode(prog_mode));
   dsd_pmem_model PM (.pmem_en(pmem_en), .pmem_addr(pmem_addr), .pmem_rdata(pmem_rdata));
   // ==========
   // Tasks
   function [7:0] rom_byte(input [11:0] x);
      rom_byte = x[7:0] ^ {x[11:8], x[11:8]};
   endfunction
   task check(input [31:0] seen, input [31:0] exp);
      begin
         comparisons = comparisons + 1;
         if (seen !== exp) begin
            failures = failures + 1;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
         end
      end
   endtask
   task final_report;
      begin
         $display("comparisons=%0d failures=%0d", comparisons, failures);
         if (failures == 0 && comparisons > 0) begin
            $display("*** PASS ***");
         end else begin
            $display("*** FAIL ***");
         end
         $finish;
      end
   endtask
   // Every operation ends at the falling edge of the cycle after it was taken.
   task cpu_op(input rd, input [7:0] ad, input [7:0] wd);
      begin
         @(posedge clk);
         cpu_addr <= ad;
         cpu_wdata <= wd;
         cpu_rd <= rd;
         cpu_wr <= !rd;
         acc_in <= $random(seed);
         periph_rdata <= $random(seed);
         @(posedge clk);
         cpu_rd <= 1'b0;
         cpu_wr <= 1'b0;
         @(negedge clk);
      end
   endtask
   task rd(input [7:0] ad, output [7:0] v);
      integer k;
      begin
         cpu_op(1'b1, ad, 8'h00);
         k = 0;
         while (cpu_rvalid !== 1'b1 && k < 4) begin
            @(negedge clk);
            k = k + 1;
         end
         check(cpu_rvalid, 1'b1);
         v = cpu_rdata;
      end
   endtask
   // ==========
   // Clock and timeout
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc = cyc + 1;
      if (cyc == 20000) begin
         failures = failures + 1;
         final_report;
      end
   end
   // ==========
   // Scenarios
   initial begin
      seed = 31;
      failures = 0;
      comparisons = 0;
      cyc = 0;
      {cpu_rd, cpu_wr, fetch_req, test_pin_high, cpu_addr, cpu_wdata, acc_in, periph_rdata, fetch_pc} = 0;
      {call_push, ret_pop, readout_protect, ext_read_req, ext_read_addr} = 0;
      sys_rst = 1'b1;
      repeat (5) @(posedge clk);
      sys_rst <= 1'b0;
      @(posedge clk);
      @(negedge clk);
      check(prog_mode, 1'b0);
      for (i = 0; i < 8; i = i + 1) begin
         d = (i == 0) ? 8'hff : (i == 1) ? 8'h00 : $random(seed);
         a = (i == 0) ? 8'h7f : (i == 1) ? 8'h40 : 8'h40 | ($random(seed) & 8'h3f);
         pos = d[5:0];
         cpu_op(1'b0, 8'hc9, d);
         rd(a, got);
         check(got, rom_byte({pos, a[5:0]}));
      end
      for (i = 0; i < 10; i = i + 1) begin
         a = (i < 6) ? RSV[i*8 +: 8] : $random(seed) & 8'h3f;
         if (i >= 2) begin
            cpu_op(1'b0, a, $random(seed));
            check({periph_wr, acc_we}, 2'b00);
         end
         rd(a, got);
         check(got, 8'hff);
      end
      for (i = 0; i < 12; i = i + 1) begin
         a = (i < 4) ? 8'h80 + i : (i == 4) ? 8'h84 : (i == 5) ? 8'hbf : 8'h84 + {$random(seed)} % 60;
         d = $random(seed);
         cpu_op(1'b0, a, d);
         if (i < 4) begin
            check(i == 0 ? ptr0_out : i == 1 ? ptr1_out : i == 2 ? sdir0_out : sdir1_out, d);
         end
         rd(a, got);
         check(got, d);
      end
      d = $random(seed);
      cpu_op(1'b0, 8'hff, d);
      check({acc_we, acc_wdata}, {1'b1, d});
      rd(8'hff, got);
      check(got, acc_in);
      for (i = 0; i < 13; i = i + 1) begin
         a = PTAB[i*8 +: 8];
         d = $random(seed);
         cpu_op(1'b0, a, d);
         check({periph_wr, periph_sel, periph_wdata}, {1'b1, 13'h0001 << i, d});
         if (a != 8'hc8) begin
            rd(a, got);
            check(got, periph_rdata);
         end
      end
      // The last fetch collides with a window read, which must win without corrupting either.
      for (i = 0; i < 4; i = i + 1) begin
         pc = (i == 0) ? 12'hfff : $random(seed);
         got = 8'hxx;
         fd = 8'hxx;
         @(posedge clk);
         fetch_pc <= pc;
         fetch_req <= 1'b1;
         cpu_addr <= 8'h40;
         cpu_rd <= (i == 3);
         @(posedge clk);
         fetch_req <= 1'b0;
         cpu_rd <= 1'b0;
         repeat (4) begin
            @(negedge clk);
            if (cpu_rvalid === 1'b1) got = cpu_rdata;
            if (fetch_valid === 1'b1) fd = fetch_data;
         end
         check(fd, rom_byte(pc));
         if (i == 3) check(got, rom_byte({pos, 6'h00}));
      end
      // Outside readout first unprotected, then protected, which must answer with a blank byte.
      for (i = 0; i < 2; i = i + 1) begin
         pc = $random(seed);
         ed = 8'hxx;
         @(posedge clk);
         readout_protect <= i[0];
         ext_read_req <= 1'b1;
         ext_read_addr <= pc;
         @(posedge clk);
         ext_read_req <= 1'b0;
         repeat (3) begin
            @(negedge clk);
            if (ext_read_valid === 1'b1) ed = ext_read_data;
         end
         check(ed, (i == 1) ? 8'hff : rom_byte(pc));
      end
      // Seven pushes overflow the six levels, then seven pops run the stack dry.
      for (i = 0; i < 14; i = i + 1) begin
         if (i < 7) pcs[i] = $random(seed);
         @(posedge clk);
         fetch_pc <= (i < 7) ? pcs[i] : 12'h000;
         call_push <= (i < 7);
         ret_pop <= (i >= 7);
         @(posedge clk);
         call_push <= 1'b0;
         ret_pop <= 1'b0;
         repeat (2) @(negedge clk);
         if (i < 7) begin
            check({stack_overflow, stack_top}, {i == 6, pcs[i]});
         end else begin
            check(stack_underflow, i == 13);
            if (i < 12) check(stack_top, pcs[12 - i]);
         end
      end
      // A second reset with the test pin high enters programming mode, which outlives the pin.
      @(posedge clk);
      test_pin_high <= 1'b1;
      sys_rst <= 1'b1;
      repeat (2) @(posedge clk);
      sys_rst <= 1'b0;
      @(posedge clk);
      @(negedge clk);
      check({prog_mode, cpu_rvalid, fetch_valid}, 3'b100);
      @(posedge clk);
      test_pin_high <= 1'b0;
      repeat (2) @(negedge clk);
      check(prog_mode, 1'b1);
      final_report;
   end
endmodule // dsd_decoder_tb_top
